// *** hdl/sgw_pkg.sv ***
// Purpose: Shared constants and types of the register write guard.
// Assumes: Byte-wide register port with an 8-bit address.
// Notes:   Every offset, field position and reset value is named here.
package sgw_pkg;

  // Register port widths
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;

  // Guard control register and its fields
  localparam logic [7:0] ACCESS_GUARD_CONTROL_OFS = 8'h00;
  localparam int         CLOCK_LVD_GROUP_GUARD_BIT = 0;
  localparam int         IRQ_GROUP_GUARD_BIT       = 1;
  localparam int         PORT_GROUP_GUARD_BIT      = 2;
  localparam int         ACCESS_DETECT_EN_BIT      = 7;
  localparam logic [7:0] ACCESS_GUARD_CONTROL_RST  = 8'h00;
  localparam logic [7:0] ACCESS_GUARD_CONTROL_MASK = 8'h87;

  // Sticky record of refused writes, one bit per group, write one to clear
  localparam logic [7:0] BLOCKED_STATUS_OFS = 8'h01;
  localparam logic [7:0] BLOCKED_STATUS_RST = 8'h00;

  // Guarded register groups: eight byte registers each
  localparam logic [3:0] PORT_GROUP_BASE  = 4'h1;
  localparam logic [3:0] IRQ_GROUP_BASE   = 4'h2;
  localparam logic [3:0] CLOCK_GROUP_BASE = 4'h3;
  localparam int         GROUP_REGS       = 8;
  localparam int         GROUP_COUNT      = 3;
  localparam int         BANK_REGS        = GROUP_REGS * GROUP_COUNT;
  localparam logic [7:0] GUARDED_REG_RST  = 8'h00;

  // Group that an address falls in
  typedef enum logic [3:0] {
    SGW_GRP_NONE  = 4'b0001,
    SGW_GRP_PORT  = 4'b0010,
    SGW_GRP_IRQ   = 4'b0100,
    SGW_GRP_CLOCK = 4'b1000
  } sgw_group_e;

endpackage

// *** hdl/sgw_gate_if.sv ***
// Purpose: Carries one write request and its guard verdict between modules.
// Assumes: Purely combinational exchange within one clock cycle.
// Notes:   The top drives the request, the gate returns group and verdict.
`timescale 1ns/10ps
interface sgw_gate_if;
  logic [sgw_pkg::ADDR_W-1:0] addr;
  logic                       wr;
  logic [2:0]                 guard_en;
  sgw_pkg::sgw_group_e        group;
  logic                       allow;
  logic                       refused;

  // Requesting side
  modport req (
    output addr,
    output wr,
    output guard_en,
    input  group,
    input  allow,
    input  refused
  );

  // Deciding side
  modport gate (
    input  addr,
    input  wr,
    input  guard_en,
    output group,
    output allow,
    output refused
  );
endinterface

// *** hdl/sgw_gate.sv ***
// Purpose: Decodes the group of an address and judges a write against it.
// Assumes: guard_en bit 0 clock group, bit 1 interrupt group, bit 2 port.
// Notes:   Combinational only; the top registers the refused verdict, group and allow drive its decode directly.
`timescale 1ns/10ps
module sgw_gate (
  // Request and verdict
  sgw_gate_if.gate g
);

  // Map the upper address nibble onto a guarded group
  function automatic sgw_pkg::sgw_group_e group_of(
    input logic [sgw_pkg::ADDR_W-1:0] a
  );
    case (a[7:4])
      sgw_pkg::PORT_GROUP_BASE:  group_of = sgw_pkg::SGW_GRP_PORT;
      sgw_pkg::IRQ_GROUP_BASE:   group_of = sgw_pkg::SGW_GRP_IRQ;
      sgw_pkg::CLOCK_GROUP_BASE: group_of = sgw_pkg::SGW_GRP_CLOCK;
      default:                   group_of = sgw_pkg::SGW_GRP_NONE;
    endcase
  endfunction

  logic guarded;

  // Pick the guard bit that covers the addressed group
  always_comb begin
    g.group = group_of(g.addr);
    case (g.group)
      sgw_pkg::SGW_GRP_PORT:
        guarded = g.guard_en[sgw_pkg::PORT_GROUP_GUARD_BIT];
      sgw_pkg::SGW_GRP_IRQ:
        guarded = g.guard_en[sgw_pkg::IRQ_GROUP_GUARD_BIT];
      sgw_pkg::SGW_GRP_CLOCK:
        guarded = g.guard_en[sgw_pkg::CLOCK_LVD_GROUP_GUARD_BIT];
      sgw_pkg::SGW_GRP_NONE:
        guarded = 1'b0;
      default:
        guarded = 1'b0;
    endcase
    g.allow   = g.wr && !guarded;
    g.refused = g.wr && guarded;
  end

endmodule

// *** hdl/sgw_write_guard.sv ***
// Purpose: Write guard for three groups of control registers, with the
//          guarded registers themselves held in a local bank.
// Assumes: Single clock; byte register port, read data one cycle later.
// Notes:   Guarded registers are always readable; only writes are gated.
`timescale 1ns/10ps

module sgw_write_guard (
  // Clock and reset
  input  wire logic                                REF_CLK,
  input  wire logic                                SRST,
  // Register port
  input  wire logic [sgw_pkg::ADDR_W-1:0]          ADDR,
  input  wire logic [sgw_pkg::DATA_W-1:0]          WDATA,
  input  wire logic                                WR,
  input  wire logic                                RD,
  output logic      [sgw_pkg::DATA_W-1:0]          RDATA,
  // Guard state and refused-write pulse
  output logic      [2:0]                          GUARD_EN,
  output logic                                     ACCESS_DETECT_EN,
  output logic                                     WR_REFUSED,
  // Contents of the guarded registers, eight bytes per group
  output logic      [sgw_pkg::BANK_REGS*8-1:0]     GUARDED_REGS
);

  // Flat bank index of an address inside a group
  function automatic logic [4:0] bank_index(
    input sgw_pkg::sgw_group_e          grp,
    input logic [sgw_pkg::ADDR_W-1:0]   a
  );
    case (grp)
      sgw_pkg::SGW_GRP_PORT:  bank_index = {2'b00, a[2:0]};
      sgw_pkg::SGW_GRP_IRQ:   bank_index = {2'b01, a[2:0]};
      sgw_pkg::SGW_GRP_CLOCK: bank_index = {2'b10, a[2:0]};
      sgw_pkg::SGW_GRP_NONE:  bank_index = 5'h00;
      default:                bank_index = 5'h00;
    endcase
  endfunction

  // Does the address hit a populated register of a group
  function automatic logic in_bank(
    input sgw_pkg::sgw_group_e          grp,
    input logic [sgw_pkg::ADDR_W-1:0]   a
  );
    in_bank = (grp != sgw_pkg::SGW_GRP_NONE) && (a[3] == 1'b0);
  endfunction

  // Registers
  logic [7:0] guard_ctrl_reg;
  logic [7:0] guard_ctrl_next;
  logic [2:0] blocked_reg;
  logic [2:0] blocked_next;
  logic [7:0] bank_reg [0:sgw_pkg::BANK_REGS-1];
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  logic       refused_reg;

  // Decode of the current access
  logic [2:0] refused_hit;
  logic [4:0] wr_idx;
  logic [4:0] rd_idx;
  logic       wr_bank;
  logic       rd_bank;
  logic       ctrl_wr;
  logic       status_wr;

  sgw_gate_if gif ();

  // Present the write to the gate with the live guard bits
  assign gif.addr     = ADDR;
  assign gif.wr       = WR;
  assign gif.guard_en = guard_ctrl_reg[2:0];

  sgw_gate u_gate (
    .g (gif.gate)
  );

  // Address decode shared by the write and read paths
  always_comb begin
    wr_idx    = bank_index(gif.group, ADDR);
    rd_idx    = bank_index(gif.group, ADDR);
    wr_bank   = gif.allow && in_bank(gif.group, ADDR);
    rd_bank   = RD && in_bank(gif.group, ADDR);
    ctrl_wr   = WR && (ADDR == sgw_pkg::ACCESS_GUARD_CONTROL_OFS);
    status_wr = WR && (ADDR == sgw_pkg::BLOCKED_STATUS_OFS);
  end

  // Guard control is never itself guarded; unused bits are not stored
  always_comb begin
    guard_ctrl_next = guard_ctrl_reg;
    if (ctrl_wr) begin
      guard_ctrl_next = WDATA & sgw_pkg::ACCESS_GUARD_CONTROL_MASK;
    end
  end

  // Guard control register; clears so no group is protected
  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      guard_ctrl_reg <= sgw_pkg::ACCESS_GUARD_CONTROL_RST;
    end else begin
      guard_ctrl_reg <= guard_ctrl_next;
    end
  end

  // Which group refused the current write
  always_comb begin
    refused_hit = 3'b000;
    if (gif.refused) begin
      case (gif.group)
        sgw_pkg::SGW_GRP_CLOCK:
          refused_hit[sgw_pkg::CLOCK_LVD_GROUP_GUARD_BIT] = 1'b1;
        sgw_pkg::SGW_GRP_IRQ:
          refused_hit[sgw_pkg::IRQ_GROUP_GUARD_BIT] = 1'b1;
        sgw_pkg::SGW_GRP_PORT:
          refused_hit[sgw_pkg::PORT_GROUP_GUARD_BIT] = 1'b1;
        default:
          refused_hit = 3'b000;
      endcase
    end
  end

  // Sticky refused-write record; a new refusal wins over a clear
  always_comb begin
    blocked_next = blocked_reg;
    if (status_wr) begin
      blocked_next = blocked_reg & ~WDATA[2:0];
    end
    blocked_next = blocked_next | refused_hit;
  end

  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      blocked_reg <= sgw_pkg::BLOCKED_STATUS_RST[2:0];
    end else begin
      blocked_reg <= blocked_next;
    end
  end

  // Guarded bank: stored only on an allowed write, else contents hold
  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      for (int i = 0; i < sgw_pkg::BANK_REGS; i++) begin
        bank_reg[i] <= sgw_pkg::GUARDED_REG_RST;
      end
    end else if (wr_bank) begin
      bank_reg[wr_idx] <= WDATA;
    end
  end

  // Read mux; the guard bits play no part here
  always_comb begin
    rdata_next = 8'h00;
    if (rd_bank) begin
      rdata_next = bank_reg[rd_idx];
    end else if (RD && (ADDR == sgw_pkg::ACCESS_GUARD_CONTROL_OFS)) begin
      rdata_next = guard_ctrl_reg;
    end else if (RD && (ADDR == sgw_pkg::BLOCKED_STATUS_OFS)) begin
      rdata_next = {5'b0_0000, blocked_reg};
    end
  end

  // Read data stands only in the cycle after the read strobe
  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      rdata_reg <= 8'h00;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  // One-cycle pulse for each refused write
  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      refused_reg <= 1'b0;
    end else begin
      refused_reg <= gif.refused;
    end
  end

  // Outputs straight from flip-flops
  assign RDATA            = rdata_reg;
  assign GUARD_EN         = guard_ctrl_reg[2:0];
  assign ACCESS_DETECT_EN = guard_ctrl_reg[sgw_pkg::ACCESS_DETECT_EN_BIT];
  assign WR_REFUSED       = refused_reg;

  // Flatten the bank, register 0 in the lowest byte
  always_comb begin
    for (int k = 0; k < sgw_pkg::BANK_REGS; k++) begin
      GUARDED_REGS[k*8 +: 8] = bank_reg[k];
    end
  end

endmodule

// *** tb/sgw_write_guard_props.sv ***
// Purpose: Port-level checks of the register write guard.
// Assumes: Bank bytes at 0x10, 0x20 and 0x30, eight per group.
// Notes:   Bound to every instance of the top module.
`timescale 1ns/10ps
module sgw_write_guard_props (
  // Clock and reset
  input wire logic         REF_CLK,
  input wire logic         SRST,
  // Register port
  input wire logic [7:0]   ADDR,
  input wire logic [7:0]   WDATA,
  input wire logic         WR,
  input wire logic         RD,
  input wire logic [7:0]   RDATA,
  // Guard state and bank
  input wire logic [2:0]   GUARD_EN,
  input wire logic         ACCESS_DETECT_EN,
  input wire logic         WR_REFUSED,
  input wire logic [191:0] GUARDED_REGS
);
  logic       hit;
  logic       grd;
  int         idx;
  int         last_idx;
  logic [7:0] cur_byte;
  logic [7:0] stored;

  // Bank decode and the guard bit that covers the address
  assign hit = ADDR[7:4] inside {4'h1, 4'h2, 4'h3} && !ADDR[3];
  assign grd = (ADDR[7:4] == 4'h1 && GUARD_EN[2]) ||
               (ADDR[7:4] == 4'h2 && GUARD_EN[1]) ||
               (ADDR[7:4] == 4'h3 && GUARD_EN[0]);
  assign idx = hit ? (int'(ADDR[7:4]) - 1) * 8 + int'(ADDR[2:0]) : 0;
  assign cur_byte = GUARDED_REGS[8*idx +: 8];
  assign stored   = GUARDED_REGS[8*last_idx +: 8];

  // Byte aimed at by the previous access
  always_ff @(posedge REF_CLK) begin
    last_idx <= idx;
  end

  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (SRST);

  a_port_guard: assert property (
    WR && ADDR[7:3] == 5'h02 && GUARD_EN[2]
    |=> WR_REFUSED && $stable(GUARDED_REGS)) else $error("port write kept");
  a_irq_guard: assert property (
    WR && ADDR[7:3] == 5'h04 && GUARD_EN[1]
    |=> WR_REFUSED && $stable(GUARDED_REGS)) else $error("irq write kept");
  a_clock_guard: assert property (
    WR && ADDR[7:3] == 5'h06 && GUARD_EN[0]
    |=> WR_REFUSED && $stable(GUARDED_REGS)) else $error("clock write kept");
  a_open_write: assert property (
    WR && hit && !grd |=> !WR_REFUSED && stored == $past(WDATA))
    else $error("open write lost");
  a_read_bank: assert property (
    RD && hit |=> RDATA == $past(cur_byte)) else $error("bank read wrong");
  a_guard_write: assert property (
    WR && ADDR == 8'h00 |=> GUARD_EN == $past(WDATA[2:0])
    && ACCESS_DETECT_EN == $past(WDATA[7])) else $error("guard write lost");
  a_guard_read: assert property (
    RD && ADDR == 8'h00 |=> RDATA == {$past(ACCESS_DETECT_EN), 4'h0,
    $past(GUARD_EN)}) else $error("guard read wrong");
  a_reset_open: assert property (
    $fell(SRST) |-> GUARD_EN == 3'h0 && GUARDED_REGS == '0)
    else $error("guard not clear after reset");
  a_rdata_idle: assert property (
    !RD |=> RDATA == 8'h00) else $error("read data not idle");

  c_refused: cover property (WR_REFUSED);
  c_all_guards: cover property (GUARD_EN == 3'h7);
  c_guarded_read: cover property (RD && hit && grd);
endmodule

bind sgw_write_guard sgw_write_guard_props sgw_write_guard_props_i (
  .REF_CLK, .SRST, .ADDR, .WDATA, .WR, .RD, .RDATA, .GUARD_EN,
  .ACCESS_DETECT_EN, .WR_REFUSED, .GUARDED_REGS
);

// *** tb/sgw_write_guard_bench.sv ***
// Purpose: Self-checking bench of the register write guard.
// Assumes: Read data in the cycle after the read strobe only.
// Notes:   Walks every group open and guarded, then the clock group through a second reset.
`timescale 1ns/10ps
`define CHK(g, e) begin \
  comparisons++; \
  if ((g) !== (e)) begin \
    mismatches++; \
    $display("ERROR t=%0t got=%h exp=%h", $time, g, e); \
  end \
end
module sgw_write_guard_bench;
  logic         ref_clk = 1'b0;
  logic         srst    = 1'b1;
  logic [7:0]   addr    = 8'h00;
  logic [7:0]   wdata   = 8'h00;
  logic         wr      = 1'b0;
  logic         rd      = 1'b0;
  logic [7:0]   rdata;
  logic [2:0]   guard_en;
  logic         det_en;
  logic         refused;
  logic [191:0] regs;
  logic [7:0]   a;
  logic [7:0]   b;
  int           comparisons = 0;
  int           mismatches  = 0;

  sgw_write_guard sgw_write_guard_i (
    .REF_CLK(ref_clk), .SRST(srst), .ADDR(addr), .WDATA(wdata), .WR(wr),
    .RD(rd), .RDATA(rdata), .GUARD_EN(guard_en), .ACCESS_DETECT_EN(det_en),
    .WR_REFUSED(refused), .GUARDED_REGS(regs)
  );

  // 40 MHz clock
  always #12.5 ref_clk = ~ref_clk;

  // One write cycle; the refused pulse is looked at in the next cycle
  task automatic wr_reg(input logic [7:0] wa, input logic [7:0] wd,
                        input logic rexp);
    @(posedge ref_clk);
    wr <= 1'b1;
    addr <= wa;
    wdata <= wd;
    @(posedge ref_clk);
    wr <= 1'b0;
    @(negedge ref_clk);
    `CHK(refused, rexp)
  endtask

  // One read cycle; data compared in the cycle after the strobe
  task automatic rd_reg(input logic [7:0] ra, input logic [7:0] rexp);
    @(posedge ref_clk);
    rd <= 1'b1;
    addr <= ra;
    @(posedge ref_clk);
    rd <= 1'b0;
    @(negedge ref_clk);
    `CHK(rdata, rexp)
  endtask

  // Counts and verdict
  task automatic results();
    $display("comparisons=%0d mismatches=%0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Hang guard
  initial begin
    #2000000;
    mismatches++;
    results();
  end

  // Main sequence
  initial begin
    repeat (5) @(posedge ref_clk);
    srst <= 1'b0;
    rd_reg(8'h00, 8'h00);
    for (int g = 0; g < 3; g++) begin
      a = 8'h17 + 8'(g * 16);
      b = 8'h04 >> g;
      wr_reg(a, 8'hA5, 1'b0);
      wr_reg(8'h00, b, 1'b0);
      `CHK(guard_en, b[2:0])
      wr_reg(a, 8'h5A, 1'b1);
      rd_reg(a, 8'hA5);
      wr_reg(8'h10 + 8'(((g + 1) % 3) * 16), 8'h11, 1'b0);
    end
    // Refused-write record, write-one-to-clear, and an unmapped bank slot
    `CHK(regs[8*8 +: 8], 8'h11)
    rd_reg(8'h01, 8'h07);
    wr_reg(8'h01, 8'h05, 1'b0);
    rd_reg(8'h01, 8'h02);
    wr_reg(8'h18, 8'hFF, 1'b0);
    rd_reg(8'h18, 8'h00);
    wr_reg(8'h00, 8'hFF, 1'b0);
    rd_reg(8'h00, 8'h87);
    `CHK(det_en, 1'b1)
    wr_reg(8'h00, 8'h00, 1'b0);
    rd_reg(8'h00, 8'h00);
    // Second reset with every guard set
    wr_reg(8'h00, 8'h07, 1'b0);
    @(posedge ref_clk);
    srst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    srst <= 1'b0;
    rd_reg(8'h00, 8'h00);
    wr_reg(8'h37, 8'h3C, 1'b0);
    rd_reg(8'h37, 8'h3C);
    results();
  end
endmodule
